// File: dcc_comp_model.sv
// behavioural pair of analog comparators and the port pin wires
`timescale 1ns/1ps
module dcc_comp_model (
   input  wire logic        clk_in,
   input  wire logic [15:0] pos_in,
   input  wire logic [15:0] neg_in,
   input  wire logic [7:0]  vref_in,
   input  wire logic        vref_sel_in,
   input  wire logic [1:0]  power_in,
   input  wire logic [7:0]  ext_in,
   input  wire logic [7:0]  pin_out_in,
   input  wire logic [7:0]  oe_in,
   output logic      [1:0]  raw_out,
   output logic      [7:0]  pin_level_out
);
   logic       junk_reg = 1'b0;
   logic [7:0] pos_a, pos_b;
   // a powered-down comparator output means nothing, so it wanders
   always @(posedge clk_in) junk_reg <= ~junk_reg;
   assign pos_a = vref_sel_in ? vref_in : pos_in[7:0];
   assign pos_b = vref_sel_in ? vref_in : pos_in[15:8];
   // comparing goes on whatever the sleep state
   assign raw_out[0] = power_in[0] ? (pos_a > neg_in[7:0]) : junk_reg;
   assign raw_out[1] = power_in[1] ? (pos_b > neg_in[15:8]) : ~junk_reg;
   assign pin_level_out = (oe_in & pin_out_in) | (~oe_in & ext_in);
endmodule

// File: dcc_map.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_IDX_INTCTL     8'h0b
`define DCC_IDX_PIRF       8'h0c
`define DCC_IDX_CFG        8'h1f
`define DCC_IDX_PORTDIR    8'h85
`define DCC_IDX_PIEN       8'h8c
`define DCC_IDX_PORTDATA   8'h05
`define DCC_IDX_STATUS     8'hc0
`define DCC_IDX_MASK       8'hc1
`define DCC_IDX_CTRL       8'hc2
`define DCC_BIT_CHG        6
`define DCC_BIT_PERIPHERAL_IRQ_GATE       6
`define DCC_BIT_GIE        7
`define DCC_BIT_OUT2       7
`define DCC_BIT_OUT1       6
`define DCC_BIT_INV2       5
`define DCC_BIT_INV1       4
`define DCC_BIT_CIS        3
`define DCC_PIN_FIRST      3
`define DCC_PIN_SECOND     4
`define DCC_RST_CFG        8'h00
`define DCC_RST_PIRF       8'h00
`define DCC_RST_PIEN       8'h00
`define DCC_RST_INTCTL     8'h00
`define DCC_RST_PORTDIR    8'hff
`define DCC_RST_STAT       2'h0
`define DCC_PIRF_WMASK     8'hf7
`define DCC_PIEN_WMASK     8'hf7
`define DCC_ADDR_UNUSED    2'h0
`define DCC_RESP_OKAY      2'h0
`define DCC_RESP_SLVERR    2'h2
`define DCC_MODE_RESET     3'h0
`define DCC_MODE_ONE_OUT   3'h1
`define DCC_MODE_VREF      3'h2
`define DCC_MODE_TWO_OUT   3'h6
`define DCC_MODE_OFF       3'h7
`endif

// File: dcc_pkg.sv
// types shared by the comparator control block
package dcc_pkg;
   typedef logic [2:0] dcc_mode_t;
   typedef enum logic [1:0] {
      DCC_W_IDLE = 2'b00,
      DCC_W_RESP = 2'b01
   } dcc_wstate_t;
endpackage

// File: dcc_sync.sv
// two-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module dcc_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// File: dcc_top.sv
// comparator mode, status, pin routing and change interrupt behind an axi4-lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_top
   import dcc_pkg::*;
#(
   parameter int NPINS = 8
) (
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic [31:0]      s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [31:0]      s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic [1:0]       comp_raw_in,
   input  wire logic             sleep_in,
   input  wire logic [NPINS-1:0] port_latch_in,
   input  wire logic [NPINS-1:0] port_pin_in,
   output logic [NPINS-1:0]      port_pin_out,
   output logic [NPINS-1:0]      port_pin_oe_out,
   output logic [NPINS-1:0]      analog_sel_out,
   output logic [1:0]            comp_power_out,
   output logic                  vref_to_pos_out,
   output logic                  first_neg_alt_out,
   output logic                  second_neg_alt_out,
   output logic                  cpu_irq_out,
   output logic                  wake_out,
   output logic                  irq_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // registers and decode
   logic [7:0]       comparator_config_reg;
   logic [7:0]       peripheral_irq_flags_reg;
   logic [7:0]       peripheral_irq_enables_reg;
   logic [7:0]       interrupt_control_reg;
   logic [7:0]       port_pin_direction_reg;
   logic [1:0]       stat_reg;
   logic [1:0]       mask_reg;
   logic [1:0]       latched_reg;
   logic [1:0]       result_sync;
   logic [1:0]       result_now;
   logic [1:0]       pin_result;
   dcc_mode_t        comparator_mode_field;
   logic             aw_held_reg;
   logic             w_held_reg;
   logic [7:0]       aw_idx_reg;
   logic [31:0]      w_data_reg;
   logic [3:0]       w_strb_reg;
   dcc_wstate_t      wstate_reg;
   logic             wr_fire;
   logic             rd_fire;
   logic [7:0]       rd_idx;
   logic             cfg_access;
   logic             mismatch;
   logic             chg_set;
   logic             chg_wr;
   logic             wr_low_lane;
   logic [31:0]      rd_word;
   logic             rd_ok;
   logic             wr_ok;
   logic [NPINS-1:0] analog_pins;
   logic [NPINS-1:0] port_read;
   logic             irq_req;

   assign comparator_mode_field = comparator_config_reg[2:0];
   assign wr_fire     = aw_held_reg && w_held_reg && (wstate_reg == DCC_W_IDLE);
   assign rd_idx      = s_axi_araddr[9:2];
   assign rd_fire     = s_axi_arvalid && s_axi_arready;
   assign wr_low_lane = w_strb_reg[0];
   assign wr_ok       = (aw_idx_reg == `DCC_IDX_INTCTL) || (aw_idx_reg == `DCC_IDX_PIRF)
                        || (aw_idx_reg == `DCC_IDX_CFG) || (aw_idx_reg == `DCC_IDX_PORTDIR)
                        || (aw_idx_reg == `DCC_IDX_PIEN) || (aw_idx_reg == `DCC_IDX_PORTDATA)
                        || (aw_idx_reg == `DCC_IDX_STATUS) || (aw_idx_reg == `DCC_IDX_MASK)
                        || (aw_idx_reg == `DCC_IDX_CTRL);
   assign cfg_access  = (rd_fire && (rd_idx == `DCC_IDX_CFG))
                        || (wr_fire && (aw_idx_reg == `DCC_IDX_CFG));

   ////////////////////////////////////////////////////////////////////////////////
   // comparator results
   dcc_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk_in   (clk_in),
      .nrst_in  (nrst_in),
      .async_in (comp_raw_in),
      .sync_out (result_sync)
   );

   // raw input high means positive above negative; gated off when powered down
   assign pin_result[0] = (comp_raw_in[0] & comp_power_out[0])
                          ^ comparator_config_reg[`DCC_BIT_INV1];
   assign pin_result[1] = (comp_raw_in[1] & comp_power_out[1])
                          ^ comparator_config_reg[`DCC_BIT_INV2];
   assign result_now[0] = (result_sync[0] & comp_power_out[0])
                          ^ comparator_config_reg[`DCC_BIT_INV1];
   assign result_now[1] = (result_sync[1] & comp_power_out[1])
                          ^ comparator_config_reg[`DCC_BIT_INV2];
   assign mismatch = (result_now != latched_reg);

   // the relatch cycle wins, so a change exactly then may go unflagged
   assign chg_set = mismatch && !cfg_access;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         latched_reg <= `DCC_RST_STAT;
      end else if (cfg_access) begin
         latched_reg <= result_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode decode
   always_comb begin
      comp_power_out     = 2'b11;
      vref_to_pos_out    = 1'b0;
      first_neg_alt_out  = 1'b0;
      second_neg_alt_out = 1'b0;
      analog_pins        = '0;
      unique case (comparator_mode_field)
         `DCC_MODE_RESET: begin
            comp_power_out = 2'b00;
            analog_pins[3:0] = 4'hf;
         end
         `DCC_MODE_ONE_OUT: begin
            analog_pins[2:0] = 3'h7;
            first_neg_alt_out = comparator_config_reg[`DCC_BIT_CIS];
         end
         `DCC_MODE_VREF: begin
            analog_pins[3:0] = 4'hf;
            vref_to_pos_out = 1'b1;
            first_neg_alt_out  = comparator_config_reg[`DCC_BIT_CIS];
            second_neg_alt_out = comparator_config_reg[`DCC_BIT_CIS];
         end
         3'h3, 3'h4, 3'h5: begin
            analog_pins[3:0] = 4'hf;
         end
         `DCC_MODE_TWO_OUT: begin
            analog_pins[2:0] = 3'h7;
         end
         `DCC_MODE_OFF: begin
            comp_power_out = 2'b00;
         end
      endcase
   end
   assign analog_sel_out = analog_pins;

   ////////////////////////////////////////////////////////////////////////////////
   // pins
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         logic routed;
         always_comb begin
            routed = 1'b0;
            if ((comparator_mode_field == `DCC_MODE_TWO_OUT)
                || (comparator_mode_field == `DCC_MODE_ONE_OUT)) begin
               routed = (gi == `DCC_PIN_FIRST) || (gi == `DCC_PIN_SECOND);
            end
         end
         assign port_pin_out[gi] = routed ? pin_result[(gi == `DCC_PIN_SECOND) ? 1 : 0]
                                          : port_latch_in[gi];
         assign port_pin_oe_out[gi] = !port_pin_direction_reg[gi] && !analog_pins[gi];
         assign port_read[gi] = analog_pins[gi] ? 1'b0 : port_pin_in[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // software registers
   assign chg_wr = wr_fire && wr_low_lane && (aw_idx_reg == `DCC_IDX_PIRF);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         peripheral_irq_flags_reg <= `DCC_RST_PIRF;
      end else begin
         if (chg_wr) begin
            peripheral_irq_flags_reg <= w_data_reg[7:0] & `DCC_PIRF_WMASK;
         end
         if (chg_set) begin
            peripheral_irq_flags_reg[`DCC_BIT_CHG] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         comparator_config_reg <= `DCC_RST_CFG;
      end else begin
         comparator_config_reg[7:6] <= result_now;
         if (wr_fire && wr_low_lane && (aw_idx_reg == `DCC_IDX_CFG)) begin
            comparator_config_reg[5:0] <= w_data_reg[5:0];
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         peripheral_irq_enables_reg <= `DCC_RST_PIEN;
         interrupt_control_reg      <= `DCC_RST_INTCTL;
         port_pin_direction_reg     <= `DCC_RST_PORTDIR;
         mask_reg                   <= `DCC_RST_STAT;
      end else if (wr_fire && wr_low_lane) begin
         if (aw_idx_reg == `DCC_IDX_PIEN) begin
            peripheral_irq_enables_reg <= w_data_reg[7:0] & `DCC_PIEN_WMASK;
         end
         if (aw_idx_reg == `DCC_IDX_INTCTL) begin
            interrupt_control_reg <= w_data_reg[7:0];
         end
         if (aw_idx_reg == `DCC_IDX_PORTDIR) begin
            port_pin_direction_reg <= w_data_reg[7:0];
         end
         if (aw_idx_reg == `DCC_IDX_MASK) begin
            mask_reg <= w_data_reg[1:0];
         end
      end
   end

   // status: bit0 flag raised, bit1 wake request; write one clears, set wins
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stat_reg <= `DCC_RST_STAT;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_fire && wr_low_lane && (aw_idx_reg == `DCC_IDX_STATUS) && w_data_reg[i]) begin
               stat_reg[i] <= 1'b0;
            end
         end
         if (chg_set) begin
            stat_reg[0] <= 1'b1;
         end
         if (wake_out) begin
            stat_reg[1] <= 1'b1;
         end
      end
   end

   assign irq_req = peripheral_irq_flags_reg[`DCC_BIT_CHG]
                    && peripheral_irq_enables_reg[`DCC_BIT_CHG]
                    && interrupt_control_reg[`DCC_BIT_PERIPHERAL_IRQ_GATE];
   assign cpu_irq_out = irq_req && interrupt_control_reg[`DCC_BIT_GIE];
   assign wake_out    = irq_req && sleep_in;
   assign irq_out     = |(stat_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         aw_idx_reg   <= 8'h00;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         wstate_reg   <= DCC_W_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DCC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         unique case (wstate_reg)
            DCC_W_IDLE: begin
               if (wr_fire) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wr_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
                  wstate_reg   <= DCC_W_RESP;
               end
            end
            DCC_W_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  aw_held_reg  <= 1'b0;
                  w_held_reg   <= 1'b0;
                  wstate_reg   <= DCC_W_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      unique case (rd_idx)
         `DCC_IDX_INTCTL:   rd_word[7:0] = interrupt_control_reg;
         `DCC_IDX_PIRF:     rd_word[7:0] = peripheral_irq_flags_reg;
         `DCC_IDX_CFG:      rd_word[7:0] = comparator_config_reg;
         `DCC_IDX_PORTDIR:  rd_word[7:0] = port_pin_direction_reg;
         `DCC_IDX_PIEN:     rd_word[7:0] = peripheral_irq_enables_reg;
         `DCC_IDX_PORTDATA: rd_word[NPINS-1:0] = port_read;
         `DCC_IDX_STATUS:   rd_word[1:0] = stat_reg;
         `DCC_IDX_MASK:     rd_word[1:0] = mask_reg;
         `DCC_IDX_CTRL:     rd_word[1:0] = latched_reg;
         default:           rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `DCC_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// File: dcc_top_asserts.sv
// concurrent checks on the comparator control block ports
`timescale 1ns/1ps
module dcc_top_asserts #(
   parameter int NPINS = 8
) (
   input wire logic             clk_in,
   input wire logic             nrst_in,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             sleep_in,
   input wire logic [NPINS-1:0] port_latch_in,
   input wire logic [NPINS-1:0] port_pin_out,
   input wire logic [NPINS-1:0] port_pin_oe_out,
   input wire logic [NPINS-1:0] analog_sel_out,
   input wire logic [1:0]       comp_power_out,
   input wire logic             vref_to_pos_out,
   input wire logic             first_neg_alt_out,
   input wire logic             second_neg_alt_out,
   input wire logic             cpu_irq_out,
   input wire logic             wake_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_done;
      s_axi_bvalid && s_axi_bready;
   endsequence
   // both halves are held one cycle after the take, and bvalid is registered off that
   property p_wr_resp; s_wr_take |-> ##2 s_axi_bvalid; endproperty
   property p_b_pulse; s_b_done |=> !s_axi_bvalid; endproperty
   property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   property p_reset;
      $rose(nrst_in) |-> comp_power_out == 2'h0 && analog_sel_out[3:0] == 4'hf
         && port_pin_oe_out == '0;
   endproperty
   property p_oe_analog; (port_pin_oe_out & analog_sel_out) == '0; endproperty
   property p_pwr_off; analog_sel_out == '0 |-> comp_power_out == 2'h0; endproperty
   property p_vref;
      vref_to_pos_out |-> comp_power_out == 2'h3 && first_neg_alt_out == second_neg_alt_out;
   endproperty
   property p_latch_path;
      analog_sel_out[3:0] == 4'hf |-> port_pin_out[4] == port_latch_in[4];
   endproperty
   property p_wake; wake_out |-> sleep_in; endproperty
   property p_irq_sleep; cpu_irq_out && sleep_in |-> wake_out; endproperty
   ////////////////////////////////////////////////////////////////////////////////
   a_wr_resp: assert property (p_wr_resp) else $error("no write response");
   a_b_pulse: assert property (p_b_pulse) else $error("write response held");
   a_rd_resp: assert property (p_rd_resp) else $error("no read response");
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
   a_reset: assert property (p_reset) else $error("bad state after reset");
   a_oe_analog: assert property (p_oe_analog) else $error("analog pin driven");
   a_pwr_off: assert property (p_pwr_off) else $error("comparator on in off mode");
   a_vref: assert property (p_vref) else $error("reference mode wrong");
   a_latch_path: assert property (p_latch_path) else $error("pin not from latch");
   a_wake: assert property (p_wake) else $error("wake outside sleep");
   a_irq_sleep: assert property (p_irq_sleep) else $error("no wake");
endmodule

// File: dcc_top_test.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_top_test;
   logic        clk_in = 1'b0;
   logic        nrst_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleep_in;
   logic        vref_to_pos_out, first_neg_alt_out, second_neg_alt_out, cpu_irq_out, wake_out;
   logic        irq_out;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, comp_raw_in, comp_power_out, resp, iv;
   logic [7:0]  port_latch_in, port_pin_in, port_pin_out, port_pin_oe_out, analog_sel_out;
   logic [7:0]  ext_pins, vref_lvl, rd_data, v;
   logic [15:0] pos_lvl, neg_lvl, n;
   int          num_errors = 0;
   int          samples_checked = 0;
   dcc_top #(.NPINS(8)) dcc_top_inst (.*);
   dcc_comp_model dcc_comp_model_inst (.clk_in(clk_in), .pos_in(pos_lvl), .neg_in(neg_lvl),
      .vref_in(vref_lvl), .vref_sel_in(vref_to_pos_out), .power_in(comp_power_out),
      .raw_out(comp_raw_in), .ext_in(ext_pins), .pin_out_in(port_pin_out),
      .oe_in(port_pin_oe_out), .pin_level_out(port_pin_in));
   always #2.5 clk_in = ~clk_in;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] amap(input logic [2:0] m);
      case (m)
         3'h1, 3'h6: amap = 8'h07;
         3'h7: amap = 8'h00;
         default: amap = 8'h0f;
      endcase
   endfunction
   function automatic logic res(input logic [7:0] p, input logic [7:0] q, input logic i);
      res = (p > q) ^ i;
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] dat);
      logic ta, tw, tb;
      ta = 1'b0;
      tw = 1'b0;
      tb = 1'b0;
      s_axi_awaddr <= {22'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, dat};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!tb) begin
         @(negedge clk_in);
         ta = ta | (s_axi_awvalid & (s_axi_awready === 1'b1));
         tw = tw | (s_axi_wvalid & (s_axi_wready === 1'b1));
         tb = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge clk_in);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge clk_in);
   endtask
   task rd(input logic [7:0] idx);
      logic ta, tr;
      ta = 1'b0;
      tr = 1'b0;
      s_axi_araddr <= {22'h0, idx, 2'h0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      while (!tr) begin
         @(negedge clk_in);
         ta = ta | (s_axi_arvalid & (s_axi_arready === 1'b1));
         tr = (s_axi_rvalid === 1'b1);
         rd_data = s_axi_rdata[7:0];
         resp = s_axi_rresp;
         @(posedge clk_in);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge clk_in);
   endtask
   task rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
      rd(idx);
      chk(nm, rd_data, e);
   endtask
   task results;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      num_errors++;
      results;
   end
   initial begin
      void'($urandom(63996));
      {nrst_in, sleep_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= '0;
      s_axi_wstrb <= 4'h1;
      {port_latch_in, ext_pins} <= 16'($urandom);
      {pos_lvl, neg_lvl, vref_lvl} <= {16'h1080, 16'h8010, 8'h80};
      repeat (4) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      rdc("reset flags", `DCC_IDX_PIRF, `DCC_RST_PIRF);
      rdc("reset config", `DCC_IDX_CFG, `DCC_RST_CFG);
      rdc("reset direction", `DCC_IDX_PORTDIR, `DCC_RST_PORTDIR);
      rdc("reset enables", `DCC_IDX_PIEN, `DCC_RST_PIEN);
      rd(8'h10);
      chk("unmapped response", resp, `DCC_RESP_SLVERR);
      wr(8'h10, 8'h00);
      chk("unmapped write", resp, `DCC_RESP_SLVERR);
      for (int m = 0; m < 8; m++) begin
         wr(`DCC_IDX_CFG, {5'h01, m[2:0]});
         @(negedge clk_in);
         chk("power", comp_power_out, (m == 0 || m == 7) ? 2'h0 : 2'h3);
         chk("reference", vref_to_pos_out, m == 2);
         chk("analog", analog_sel_out, amap(m[2:0]));
         chk("switch", {second_neg_alt_out, first_neg_alt_out}, {m == 2, m == 1 || m == 2});
         @(posedge clk_in);
         rdc("port data", `DCC_IDX_PORTDATA, ext_pins & ~amap(m[2:0]));
      end
      wr(`DCC_IDX_CFG, 8'hc7);
      rdc("result bits", `DCC_IDX_CFG, 8'h07);
      wr(`DCC_IDX_CFG, 8'h01);
      wr(`DCC_IDX_PORTDIR, 8'he7);
      @(negedge clk_in);
      chk("routed pins", port_pin_out[4:3], 2'h1);
      chk("pin drivers", port_pin_oe_out[4:3], 2'h3);
      @(posedge clk_in);
      neg_lvl <= 16'h80f0;
      @(negedge clk_in);
      chk("unsynchronised pin", port_pin_out[3], 1'b0);
      @(posedge clk_in);
      wr(`DCC_IDX_PORTDIR, 8'hff);
      @(negedge clk_in);
      chk("pin drivers off", port_pin_oe_out[4:3], 2'h0);
      @(posedge clk_in);
      wr(`DCC_IDX_CFG, 8'h03);
      @(negedge clk_in);
      chk("latch pins", port_pin_out[4:3], port_latch_in[4:3]);
      @(posedge clk_in);
      neg_lvl <= 16'h1010;
      wr(`DCC_IDX_CFG, 8'h02);
      repeat (6) @(posedge clk_in);
      rdc("results", `DCC_IDX_CFG, 8'hc2);
      wr(`DCC_IDX_PIRF, 8'h00);
      rdc("flag cleared", `DCC_IDX_PIRF, 8'h00);
      wr(`DCC_IDX_PIEN, 8'h40);
      chk("write response", resp, `DCC_RESP_OKAY);
      wr(`DCC_IDX_INTCTL, 8'hc0);
      neg_lvl <= 16'h10f0;
      repeat (6) @(posedge clk_in);
      rdc("flag on change", `DCC_IDX_PIRF, 8'h40);
      @(negedge clk_in);
      chk("interrupt", cpu_irq_out, 1'b1);
      @(posedge clk_in);
      wr(`DCC_IDX_PIRF, 8'h00);
      rdc("mismatch", `DCC_IDX_PIRF, 8'h40);
      rdc("relatch", `DCC_IDX_CFG, 8'h82);
      rdc("latched view", `DCC_IDX_CTRL, 8'h02);
      wr(`DCC_IDX_PIRF, 8'h00);
      rdc("flag clear", `DCC_IDX_PIRF, 8'h00);
      wr(`DCC_IDX_PIRF, 8'h40);
      rdc("flag by write", `DCC_IDX_PIRF, 8'h40);
      sleep_in <= 1'b1;
      @(negedge clk_in);
      chk("wake", wake_out, 1'b1);
      @(posedge clk_in);
      sleep_in <= 1'b0;
      rdc("config after wake", `DCC_IDX_CFG, 8'h82);
      wr(`DCC_IDX_INTCTL, 8'h40);
      @(negedge clk_in);
      chk("gated interrupt", cpu_irq_out, 1'b0);
      @(posedge clk_in);
      rdc("flag kept", `DCC_IDX_PIRF, 8'h40);
      s_axi_wstrb <= 4'h0;
      wr(`DCC_IDX_PIEN, 8'h00);
      chk("strobe response", resp, `DCC_RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      rdc("strobe off", `DCC_IDX_PIEN, 8'h40);
      wr(`DCC_IDX_MASK, 8'h01);
      @(negedge clk_in);
      chk("irq line", irq_out, 1'b1);
      @(posedge clk_in);
      wr(`DCC_IDX_MASK, 8'h00);
      @(negedge clk_in);
      chk("irq masked", irq_out, 1'b0);
      @(posedge clk_in);
      wr(`DCC_IDX_MASK, 8'h03);
      wr(`DCC_IDX_STATUS, 8'h03);
      @(negedge clk_in);
      chk("irq cleared", irq_out, 1'b0);
      @(posedge clk_in);
      for (int i = 0; i < 24; i++) begin
         v = 8'($urandom);
         n = 16'($urandom);
         iv = 2'($urandom);
         if (n[7:0] == v) n[7:0] = ~v;
         if (n[15:8] == v) n[15:8] = ~v;
         {vref_lvl, neg_lvl} <= {v, n};
         wr(`DCC_IDX_CFG, {2'h0, iv, 4'h2});
         repeat (6) @(posedge clk_in);
         rdc("random results", `DCC_IDX_CFG, {res(v, n[15:8], iv[1]), res(v, n[7:0], iv[0]), iv, 4'h2});
      end
      results;
   end
endmodule
bind dcc_top dcc_top_asserts #(.NPINS(NPINS)) dcc_top_asserts_inst (.*);
